// ### hw/slsf_lane_status_bank.sv
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/1ns
`default_nettype none
// Summary of operation
// RULE1: disparity flag high when count reaches threshold
// RULE2: invalid code flag high at threshold
// RULE3: stray control flag high at threshold
// RULE4: deskew flag shows interlane alignment achieved
// RULE5: initial alignment flag shows lane sync
// RULE6: checksum flag shows received checksum matches
// RULE7: frame sync flag shows frame alignment
// RULE8: code group flag shows code group sync
// RULE9: flags show the link chosen by page
// RULE10: one byte register per lane, fixed layout
// RULE11: flags reset to zero, writes ignored
// RULE12: flags follow live state, never latched
module slsf_lane_status_bank #(
  parameter int unsigned NUM_LINKS = slsf_pkg::DEF_NUM_LINKS,
  parameter int unsigned NUM_LANES = slsf_pkg::DEF_NUM_LANES
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [slsf_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [slsf_pkg::DATA_W-1:0] avs_writedata,
  input wire logic [slsf_pkg::BE_W-1:0] avs_byteenable,
  output logic [slsf_pkg::DATA_W-1:0] avs_readdata,
  output logic avs_waitrequest,
  output logic irq,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] disparity_err_count,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] invalid_code_count,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] stray_control_count,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0] deskew_ok,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0] initial_align_ok,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0] config_sum_ok,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0] frame_sync_ok,
  input wire logic [NUM_LINKS-1:0][NUM_LANES-1:0] code_group_sync_ok
);
  import slsf_pkg::*;

  localparam int unsigned PAGE_W = (NUM_LINKS > 1) ? $clog2(NUM_LINKS) : 1;
  localparam int unsigned LSEL_W = (NUM_LANES > 1) ? $clog2(NUM_LANES) : 1;
  localparam logic [IDX_W-1:0] LANES_IDX = IDX_W'(NUM_LANES);
  localparam logic [PAGE_W:0] LINKS_PAGE = (PAGE_W + 1)'(NUM_LINKS);

  // ==========================================================================
  // state
  typedef struct packed {
    logic [NUM_LANES-1:0][FLAG_W-1:0] status;
    logic [PAGE_W-1:0] link_page;
    logic [LANE_CNT_W-1:0] error_count_threshold;
    logic [NUM_LANES-1:0] irq_status;
    logic [NUM_LANES-1:0] irq_mask;
    logic waitreq;
    logic [DATA_W-1:0] rdata;
    logic irq;
  } slsf_state_s;

  slsf_state_s state_reg;
  slsf_state_s state_next;

  logic [NUM_LINKS-1:0][NUM_LANES-1:0][FLAG_W-1:0] link_flags;
  logic [NUM_LANES-1:0][FLAG_W-1:0] cur_flags;
  logic [DATA_W-1:0] rd_mux;
  logic [IDX_W-1:0] idx;
  logic [IDX_W-1:0] lane_off;
  logic [LSEL_W-1:0] lane_sel;
  logic lane_hit;
  logic req;
  logic accept;

  assign idx = avs_address[ADDR_W-1:WORD_SHIFT];
  assign lane_off = idx - IDX_LANE_BASE;
  assign lane_sel = lane_off[LSEL_W-1:0];
  assign lane_hit = lane_off < LANES_IDX;
  assign req = avs_read | avs_write;
  assign accept = req & ~state_reg.waitreq;

  // ==========================================================================
  // per link, per lane flag builders
  for (genvar k = 0; k < NUM_LINKS; k++) begin : g_link
    for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane
      slsf_lane_flags #(
        .CNT_W(LANE_CNT_W)
      ) u_flags (
        .disparity_err_count(disparity_err_count[k][l]),
        .invalid_code_count(invalid_code_count[k][l]),
        .stray_control_count(stray_control_count[k][l]),
        .error_count_threshold(state_reg.error_count_threshold),
        .deskew_ok(deskew_ok[k][l]),
        .initial_align_ok(initial_align_ok[k][l]),
        .config_sum_ok(config_sum_ok[k][l]),
        .frame_sync_ok(frame_sync_ok[k][l]),
        .code_group_sync_ok(code_group_sync_ok[k][l]),
        .flags(link_flags[k][l])
      );
    end
  end

  // ==========================================================================
  // link paging
  always_comb begin
    cur_flags = '0;
    // RULE9 select paged link
    if ({1'b0, state_reg.link_page} < LINKS_PAGE) begin
      cur_flags = link_flags[state_reg.link_page];
    end
  end

  // ==========================================================================
  // read decode
  always_comb begin
    rd_mux = '0;
    // RULE10 lane byte map
    if (lane_hit) begin
      rd_mux[FLAG_W-1:0] = state_reg.status[lane_sel];
    end else if (idx == IDX_LINK_PAGE) begin
      rd_mux[PAGE_W-1:0] = state_reg.link_page;
    end else if (idx == IDX_ERR_THRESHOLD) begin
      rd_mux[LANE_CNT_W-1:0] = state_reg.error_count_threshold;
    end else if (idx == IDX_IRQ_STATUS) begin
      rd_mux[NUM_LANES-1:0] = state_reg.irq_status;
    end else if (idx == IDX_IRQ_MASK) begin
      rd_mux[NUM_LANES-1:0] = state_reg.irq_mask;
    end
  end

  // ==========================================================================
  // next state
  always_comb begin
    state_next = state_reg;
    // RULE12 live flag update
    state_next.status = cur_flags;
    // one wait cycle, then a single ready cycle per request
    state_next.waitreq = ~(req & state_reg.waitreq);
    if (req && state_reg.waitreq) begin
      state_next.rdata = avs_read ? rd_mux : '0;
    end
    if (accept && avs_write && avs_byteenable[0]) begin
      // RULE11 lane flags not writable
      if (idx == IDX_LINK_PAGE) begin
        state_next.link_page = avs_writedata[PAGE_W-1:0];
      end else if (idx == IDX_ERR_THRESHOLD) begin
        state_next.error_count_threshold = avs_writedata[LANE_CNT_W-1:0];
      end else if (idx == IDX_IRQ_MASK) begin
        state_next.irq_mask = avs_writedata[NUM_LANES-1:0];
      end
    end
    // only the bits that were returned are cleared
    if (accept && avs_read && idx == IDX_IRQ_STATUS) begin
      state_next.irq_status = state_reg.irq_status & ~state_reg.rdata[NUM_LANES-1:0];
    end
    // a change of any flag of a lane sets its event bit, set beats clear
    for (int i = 0; i < NUM_LANES; i++) begin
      if (cur_flags[i] != state_reg.status[i]) begin
        state_next.irq_status[i] = 1'b1;
      end
    end
    state_next.irq = |(state_next.irq_status & state_next.irq_mask);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      // RULE11 flags reset zero
      state_reg.status <= {NUM_LANES{FLAGS_RST}};
      state_reg.link_page <= '0;
      state_reg.error_count_threshold <= THRESHOLD_RST;
      state_reg.irq_status <= '0;
      state_reg.irq_mask <= '0;
      state_reg.waitreq <= 1'b1;
      state_reg.rdata <= '0;
      state_reg.irq <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  assign avs_readdata = state_reg.rdata;
  assign avs_waitrequest = state_reg.waitreq;
  assign irq = state_reg.irq;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic [LANE_CNT_W-1:0] thr;
  logic [PAGE_W-1:0] pg;
  assign thr = state_reg.error_count_threshold;
  assign pg = state_reg.link_page;

  // RULE1 disparity flag check
  disparity_flag_a: assert property ( // RULE1
    1'b1 |=> state_reg.status[0][BIT_DISPARITY] ==
      $past(disparity_err_count[pg][0] >= thr))
    else $error("disparity flag does not follow count versus threshold");

  // RULE2 invalid code check
  invalid_code_a: assert property ( // RULE2
    (invalid_code_count[pg][0] >= thr) |=> state_reg.status[0][BIT_INVALID_CODE])
    else $error("invalid code flag low with count at threshold");

  // RULE3 stray control check
  stray_control_a: assert property ( // RULE3
    (stray_control_count[pg][0] < thr) |=> !state_reg.status[0][BIT_STRAY_CONTROL])
    else $error("stray control flag high with count below threshold");

  // RULE4 deskew flag check
  deskew_flag_a: assert property ( // RULE4
    1'b1 |=> state_reg.status[NUM_LANES-1][BIT_DESKEW] == $past(deskew_ok[pg][NUM_LANES-1]))
    else $error("deskew flag does not follow deskew state");

  // RULE5 initial alignment check
  init_align_a: assert property ( // RULE5
    $fell(initial_align_ok[pg][0]) && $stable(pg) |=> !state_reg.status[0][BIT_INITIAL_ALIGN])
    else $error("initial alignment flag stays high after loss");

  // RULE6 checksum flag check
  config_sum_a: assert property ( // RULE6
    config_sum_ok[pg][0] |=> state_reg.status[0][BIT_CONFIG_SUM])
    else $error("checksum flag low while checksum matches");

  // RULE7 frame sync check
  frame_sync_a: assert property ( // RULE7
    !frame_sync_ok[pg][0] |=> !state_reg.status[0][BIT_FRAME_SYNC])
    else $error("frame sync flag high while sync lost");

  // RULE8 code group check
  code_group_a: assert property ( // RULE8
    1'b1 |=> state_reg.status[0][BIT_CODE_GROUP] == $past(code_group_sync_ok[pg][0]))
    else $error("code group flag does not follow sync state");

  // RULE9 page write check
  page_write_a: assert property ( // RULE9
    accept && avs_write && avs_byteenable[0] && idx == IDX_LINK_PAGE
      |=> pg == $past(avs_writedata[PAGE_W-1:0])
      ##1 state_reg.status[0][BIT_FRAME_SYNC] == $past(frame_sync_ok[pg][0]))
    else $error("lane view does not follow the written link page");

  // RULE10 lane readback check
  lane_read_a: assert property ( // RULE10
    avs_read && state_reg.waitreq && idx == IDX_LANE6_LINK_HEALTH
      |=> !avs_waitrequest && avs_readdata == {{(DATA_W-FLAG_W){1'b0}}, $past(state_reg.status[1])})
    else $error("lane register read returns wrong data");

  // RULE11 write ignored check
  ro_write_a: assert property ( // RULE11
    accept && avs_write && lane_hit
      |=> state_reg.status == $past(cur_flags))
    else $error("write to a lane register disturbed a flag");

  // RULE12 flag clears check
  flag_clears_a: assert property ( // RULE12
    state_reg.status[0][BIT_DISPARITY] && disparity_err_count[pg][0] < thr
      |=> !state_reg.status[0][BIT_DISPARITY])
    else $error("disparity flag held after condition went away");

  bus_answer_a: assert property (
    req |-> ##[0:1] !avs_waitrequest)
    else $error("bus request not answered within one cycle");

  irq_level_a: assert property (
    irq == |(state_reg.irq_status & state_reg.irq_mask))
    else $error("interrupt level does not match masked status");

  // RULE1 threshold write check
  thr_write_a: assert property ( // RULE1
    accept && avs_write && avs_byteenable[0] && idx == IDX_ERR_THRESHOLD
      |=> thr == $past(avs_writedata[LANE_CNT_W-1:0]))
    else $error("threshold write did not land");

  mask_write_a: assert property (
    accept && avs_write && avs_byteenable[0] && idx == IDX_IRQ_MASK
      |=> state_reg.irq_mask == $past(avs_writedata[NUM_LANES-1:0]))
    else $error("mask write did not land");

  byte_enable_a: assert property (
    accept && avs_write && !avs_byteenable[0]
      |=> $stable(thr) && $stable(pg) && $stable(state_reg.irq_mask))
    else $error("write without byte lane zero changed a register");

  // RULE10 lane seven readback
  lane7_read_a: assert property ( // RULE10
    avs_read && state_reg.waitreq && idx == IDX_LANE7_LINK_HEALTH
      |=> avs_readdata == {{(DATA_W-FLAG_W){1'b0}}, $past(state_reg.status[NUM_LANES-1])})
    else $error("lane seven read returns wrong data");

  wait_single_a: assert property (
    !avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");

  idle_wait_a: assert property (
    !req |=> avs_waitrequest)
    else $error("waitrequest low without a request");

  write_rdata_a: assert property (
    avs_write && state_reg.waitreq |=> avs_readdata == '0)
    else $error("write answer carries nonzero read data");

  irq_clear_a: assert property (
    accept && avs_read && idx == IDX_IRQ_STATUS && cur_flags == state_reg.status
      |=> (state_reg.irq_status & $past(avs_readdata[NUM_LANES-1:0])) == '0)
    else $error("status read did not clear the returned event bits");

  // ==========================================================================
  // per lane checks
  for (genvar l = 0; l < NUM_LANES; l++) begin : g_lane_chk
    // RULE1 disparity per lane
    lane_disp_a: assert property ( // RULE1
      1'b1 |=> state_reg.status[l][BIT_DISPARITY] ==
        $past(disparity_err_count[pg][l] >= thr))
      else $error("lane disparity flag does not follow its count");

    // RULE2 invalid code per lane
    lane_code_a: assert property ( // RULE2
      1'b1 |=> state_reg.status[l][BIT_INVALID_CODE] ==
        $past(invalid_code_count[pg][l] >= thr))
      else $error("lane invalid code flag does not follow its count");

    // RULE9 lane view check
    lane_view_a: assert property ( // RULE9
      {1'b0, pg} < LINKS_PAGE |=> state_reg.status[l] == $past(link_flags[pg][l]))
      else $error("lane status does not show the paged link");

    // RULE12 change sets event
    event_set_a: assert property ( // RULE12
      cur_flags[l] != state_reg.status[l] |=> state_reg.irq_status[l])
      else $error("lane flag change did not set its event bit");
  end

  lane_read_c: cover property (
    avs_read && lane_hit ##1 !avs_waitrequest && avs_readdata != '0);
  page_switch_c: cover property (
    accept && avs_write && idx == IDX_LINK_PAGE ##2 $changed(state_reg.status));
  irq_raise_c: cover property (
    $rose(irq) ##[1:20] accept && avs_read && idx == IDX_IRQ_STATUS);
  threshold_c: cover property (
    $rose(state_reg.status[0][BIT_DISPARITY]));
  irq_clear_c: cover property (
    accept && avs_read && idx == IDX_IRQ_STATUS ##1 state_reg.irq_status == '0);
endmodule : slsf_lane_status_bank
`default_nettype wire

// ### pkg/slsf_pkg.sv
`default_nettype none
package slsf_pkg;
  // ==========================================================================
  // bus geometry
  localparam int unsigned ADDR_W = 13;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned BE_W = 4;
  localparam int unsigned IDX_W = 11;
  localparam int unsigned WORD_SHIFT = 2;

  // ==========================================================================
  // register indices, byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_LINK_PAGE = 11'h300;
  localparam logic [IDX_W-1:0] IDX_LANE_BASE = 11'h4b5;
  localparam logic [IDX_W-1:0] IDX_LANE6_LINK_HEALTH = 11'h4b6;
  localparam logic [IDX_W-1:0] IDX_LANE7_LINK_HEALTH = 11'h4b7;
  localparam logic [IDX_W-1:0] IDX_ERR_THRESHOLD = 11'h310;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 11'h311;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK = 11'h312;

  // ==========================================================================
  // lane status field layout
  localparam int unsigned FLAG_W = 8;
  localparam int unsigned LANE_CNT_W = 8;
  localparam int unsigned BIT_DISPARITY = 7;
  localparam int unsigned BIT_INVALID_CODE = 6;
  localparam int unsigned BIT_STRAY_CONTROL = 5;
  localparam int unsigned BIT_DESKEW = 4;
  localparam int unsigned BIT_INITIAL_ALIGN = 3;
  localparam int unsigned BIT_CONFIG_SUM = 2;
  localparam int unsigned BIT_FRAME_SYNC = 1;
  localparam int unsigned BIT_CODE_GROUP = 0;

  // ==========================================================================
  // reset values and defaults
  localparam logic [FLAG_W-1:0] FLAGS_RST = 8'h00;
  localparam logic [LANE_CNT_W-1:0] THRESHOLD_RST = 8'h01;
  localparam int unsigned DEF_NUM_LINKS = 2;
  localparam int unsigned DEF_NUM_LANES = 3;
endpackage : slsf_pkg
`default_nettype wire

// ### hw/slsf_lane_flags.sv
`timescale 1ns/1ns
`default_nettype none
module slsf_lane_flags #(
  parameter int unsigned CNT_W = slsf_pkg::LANE_CNT_W
) (
  input wire logic [CNT_W-1:0] disparity_err_count,
  input wire logic [CNT_W-1:0] invalid_code_count,
  input wire logic [CNT_W-1:0] stray_control_count,
  input wire logic [CNT_W-1:0] error_count_threshold,
  input wire logic deskew_ok,
  input wire logic initial_align_ok,
  input wire logic config_sum_ok,
  input wire logic frame_sync_ok,
  input wire logic code_group_sync_ok,
  output logic [slsf_pkg::FLAG_W-1:0] flags
);
  import slsf_pkg::*;

  // ==========================================================================
  // RULE1 disparity count compare
  assign flags[BIT_DISPARITY] = disparity_err_count >= error_count_threshold;
  // RULE2 invalid code compare
  assign flags[BIT_INVALID_CODE] = invalid_code_count >= error_count_threshold;
  // RULE3 stray control compare
  assign flags[BIT_STRAY_CONTROL] = stray_control_count >= error_count_threshold;
  // RULE4 deskew state bit
  assign flags[BIT_DESKEW] = deskew_ok;
  // RULE5 initial alignment bit
  assign flags[BIT_INITIAL_ALIGN] = initial_align_ok;
  // RULE6 checksum match bit
  assign flags[BIT_CONFIG_SUM] = config_sum_ok;
  // RULE7 frame sync bit
  assign flags[BIT_FRAME_SYNC] = frame_sync_ok;
  // RULE8 code group bit
  assign flags[BIT_CODE_GROUP] = code_group_sync_ok;
endmodule : slsf_lane_flags
`default_nettype wire

// ### test/slsf_tx_model.sv
`timescale 1ns/1ns
`default_nettype none
// ============================================================================
// far-end transmitter model: drives live lane counts and lane states
module slsf_tx_model #(
  parameter int unsigned NUM_LINKS = 2,
  parameter int unsigned NUM_LANES = 3
) (
  input wire logic clk,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] disparity_err_count,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] invalid_code_count,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0][slsf_pkg::LANE_CNT_W-1:0] stray_control_count,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0] deskew_ok,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0] initial_align_ok,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0] config_sum_ok,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0] frame_sync_ok,
  output logic [NUM_LINKS-1:0][NUM_LANES-1:0] code_group_sync_ok
);
  import slsf_pkg::*;
  initial begin
    disparity_err_count = '0;
    invalid_code_count = '0;
    stray_control_count = '0;
    {deskew_ok, initial_align_ok, config_sum_ok} = '0;
    {frame_sync_ok, code_group_sync_ok} = '0;
  end
  // one lane of one link changes just after a rising edge
  task set_lane(input int lk, input int ln, input logic [7:0] cd, input logic [7:0] ci,
                input logic [7:0] cs, input logic [4:0] st);
    @(posedge clk);
    disparity_err_count[lk][ln] <= cd;
    invalid_code_count[lk][ln] <= ci;
    stray_control_count[lk][ln] <= cs;
    deskew_ok[lk][ln] <= st[4];
    initial_align_ok[lk][ln] <= st[3];
    config_sum_ok[lk][ln] <= st[2];
    frame_sync_ok[lk][ln] <= st[1];
    code_group_sync_ok[lk][ln] <= st[0];
  endtask : set_lane
endmodule : slsf_tx_model
`default_nettype wire

// ### test/tb_top.sv
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import slsf_pkg::*;
  localparam logic [12:0] A_L5 = 13'h12d4;
  localparam logic [12:0] A_L6 = 13'h12d8;
  localparam logic [12:0] A_L7 = 13'h12dc;
  logic clk, rst, avs_read, avs_write, avs_waitrequest, irq;
  logic [12:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0] avs_byteenable;
  logic [1:0][2:0][7:0] dc, ic, sc;
  logic [1:0][2:0] dk, ia, cf, fs, cg;
  int error_cnt, checked, cyc, k;
  slsf_lane_status_bank u_slsf_lane_status_bank (.clk(clk), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .irq(irq),
    .disparity_err_count(dc), .invalid_code_count(ic), .stray_control_count(sc),
    .deskew_ok(dk), .initial_align_ok(ia), .config_sum_ok(cf), .frame_sync_ok(fs),
    .code_group_sync_ok(cg));
  slsf_tx_model u_slsf_tx_model (.clk(clk), .disparity_err_count(dc),
    .invalid_code_count(ic), .stray_control_count(sc), .deskew_ok(dk),
    .initial_align_ok(ia), .config_sum_ok(cf), .frame_sync_ok(fs), .code_group_sync_ok(cg));
  always #4 clk = ~clk;
  // ==========================================================================
  // closing report and comparisons
  task report_and_stop;
    $display("mismatches %0d comparisons %0d", error_cnt, checked);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : report_and_stop
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // ==========================================================================
  // avalon master: hold request until waitrequest sampled low
  task bus(input logic wr, input logic [12:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= ~wr;
    avs_writedata <= d;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) chk(32'hdead, 32'h0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  task rd(input logic [12:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================================
  // test sequence
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    {avs_read, avs_write} = 2'b00;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hf;
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    for (k = 0; k < 3; k++) rd(A_L5 + 13'(4 * k), 32'h0);
    bus(1'b1, 13'hc40, 32'h10);
    rd(13'hc40, 32'h10);
    // one counter at the threshold, the others one below
    for (k = 0; k < 3; k++) begin
      u_slsf_tx_model.set_lane(0, 1, (k == 0) ? 8'h10 : 8'h0f, (k == 1) ? 8'h10 : 8'h0f,
                               (k == 2) ? 8'h10 : 8'h0f, 5'h0);
      rd(A_L6, 32'(8'h80 >> k));
    end
    u_slsf_tx_model.set_lane(0, 1, 8'h11, 8'hff, 8'h11, 5'h0);
    rd(A_L6, 32'he0);
    u_slsf_tx_model.set_lane(0, 1, 8'h0f, 8'h00, 8'h0f, 5'h0);
    rd(A_L6, 32'h0);
    // each lane state bit alone
    for (k = 0; k < 5; k++) begin
      u_slsf_tx_model.set_lane(0, 2, 8'h0, 8'h0, 8'h0, 5'(1 << k));
      rd(A_L7, 32'(1 << k));
    end
    // second link differs; paging selects which one is shown
    u_slsf_tx_model.set_lane(1, 2, 8'hff, 8'h00, 8'h00, 5'h15);
    rd(A_L7, 32'h10);
    bus(1'b1, 13'hc00, 32'h1);
    rd(A_L7, 32'h95);
    rd(A_L5, 32'h0);
    bus(1'b1, 13'hc00, 32'h0);
    rd(A_L7, 32'h10);
    bus(1'b1, A_L7, 32'hff);
    rd(A_L7, 32'h10);
    rd(13'h1ffc, 32'h0);
    // lane five with every condition met, then all lost
    u_slsf_tx_model.set_lane(0, 0, 8'h20, 8'h20, 8'h20, 5'h1f);
    rd(A_L5, 32'hff);
    u_slsf_tx_model.set_lane(0, 0, 8'h00, 8'h00, 8'h00, 5'h00);
    rd(A_L5, 32'h0);
    // a write without byte lane zero changes nothing
    avs_byteenable <= 4'he;
    bus(1'b1, 13'hc40, 32'h55);
    avs_byteenable <= 4'hf;
    rd(13'hc40, 32'h10);
    // interrupt: clear, unmask lane 7, raise, clear, masked lane
    bus(1'b0, 13'hc44, 32'h0);
    chk({31'h0, irq}, 32'h0);
    bus(1'b1, 13'hc48, 32'h4);
    rd(13'hc48, 32'h4);
    u_slsf_tx_model.set_lane(0, 2, 8'h0, 8'h0, 8'h0, 5'h0);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h1);
    rd(13'hc44, 32'h4);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    u_slsf_tx_model.set_lane(0, 1, 8'h0, 8'h0, 8'h0, 5'h1);
    repeat (3) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    rd(13'hc44, 32'h2);
    rd(A_L6, 32'h1);
    report_and_stop();
  end
endmodule : tb_top
`default_nettype wire
